// file: chan_cfg_checker_assertions.sv
// concurrent checks on the channel config bank ports
module chan_cfg_checker
  import chan_cfg_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst_n,
  input wire logic           cmdValid,
  input wire logic     [7:0] cmdByte,
  input wire logic     [7:0] wrData,
  input wire logic     [7:0] rdData,
  input wire logic           rdValid,
  input wire logic           gciPortSel,
  input wire logic           gciLineAccess,
  input wire logic     [2:0] gciLineState,
  input wire filter_cfg_t    filterCfg,
  input wire codec_mode_t    codecMode,
  input wire line_mode_t     lineMode,
  input wire gen_meter_cfg_t genMeterCfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [6:0] idx = cmdByte[6:0];
  wire rd = cmdValid && cmdByte[7];
  wire wr = cmdValid && !cmdByte[7];
  wire wF = wr && idx == IDX_FILTER;
  wire wM = wr && idx == IDX_MODE;
  a_read_answer: assert property (rd |=> rdValid)
    else $error("read not answered");
  a_valid_pulse: assert property (!rd |=> !rdValid)
    else $error("stray read valid");
  a_filter_write: assert property (wF |=>
    filterCfg == {~$past(wrData[7]), $past(wrData[6:0])})
    else $error("filter bits wrong");
  a_filter_hold: assert property (!wF |=> $stable(filterCfg))
    else $error("filter changed unasked");
  a_codec_write: assert property (wM |=>
    codecMode[4:1] == $past(wrData[7:4])) else $error("codec mode wrong");
  a_gci_line: assert property (gciPortSel |->
    lineMode == {gciLineAccess, gciLineState}) else $error("gci mux wrong");
  a_line_write: assert property (wM ##1 !gciPortSel |->
    lineMode == $past(wrData[3:0])) else $error("line mode wrong");
  a_ring_write: assert property (wr && idx == IDX_RING |=>
    codecMode.ringing == $past(wrData[4]) &&
    genMeterCfg[11:7] == {$past(wrData[5]), $past(wrData[3:0])})
    else $error("ring reg wrong");
  a_meter_write: assert property (wr && idx == IDX_METER |=>
    genMeterCfg[6:0] == {$past(wrData[7]), $past(wrData[5:0])})
    else $error("meter reg wrong");
  a_unmapped_zero: assert property (rd && (idx < 4 || idx > 7) |=>
    rdData == 8'h00) else $error("unmapped read not zero");
  c_read: cover property (rd ##1 rdValid);
  c_gci: cover property (gciPortSel);
  c_mode: cover property (wM);
endmodule // chan_cfg_checker

bind channel_mode_filter_config_regs chan_cfg_checker u_chan_cfg_checker (
  .sys_clk, .rst_n, .cmdValid, .cmdByte, .wrData, .rdData, .rdValid,
  .gciPortSel, .gciLineAccess, .gciLineState, .filterCfg, .codecMode,
  .lineMode, .genMeterCfg);

// file: chan_cfg_pkg.sv
// register map, field layouts and command coding for the channel config bank
package chan_cfg_pkg;

  // ----------------------------------------------------------------
  // command byte
  // ----------------------------------------------------------------
  localparam int CMD_DIR_BIT = 7;
  localparam logic [6:0] IDX_FILTER = 7'h04;
  localparam logic [6:0] IDX_MODE   = 7'h05;
  localparam logic [6:0] IDX_RING   = 7'h06;
  localparam logic [6:0] IDX_METER  = 7'h07;

  // ----------------------------------------------------------------
  // reset values and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FILTER = 8'hBF;
  localparam logic [7:0] RST_MODE   = 8'h80;
  localparam logic [7:0] RST_RING   = 8'h00;
  localparam logic [7:0] RST_METER  = 8'h00;
  localparam logic [7:0] RD_IDLE    = 8'h00;
  localparam logic [7:0] MASK_FILTER = 8'hFF;
  localparam logic [7:0] MASK_MODE   = 8'hFF;
  localparam logic [7:0] MASK_RING   = 8'h3F;
  localparam logic [7:0] MASK_METER  = 8'hBF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLT_MODEM  = 7;
  localparam int FLT_HPF    = 6;
  localparam int FLT_BAND   = 5;
  localparam int FLT_NOTCH  = 4;
  localparam int FLT_TONE   = 3;
  localparam int FLT_SIG    = 2;
  localparam int FLT_FEED   = 1;
  localparam int FLT_RING   = 0;
  localparam int MD_PDOWN   = 7;
  localparam int MD_STBY    = 6;
  localparam int MD_ACTIVE  = 5;
  localparam int MD_RAMP    = 4;
  localparam int MD_SCAN    = 3;
  localparam int MD_SM_HI   = 2;
  localparam int RG_IMP     = 5;
  localparam int RG_RING    = 4;
  localparam int RG_TRIP    = 3;
  localparam int RG_RINGEN  = 2;
  localparam int RG_TG2     = 1;
  localparam int RG_TG1     = 0;
  localparam int MT_RAMPEN  = 7;
  localparam int MT_NOTCH   = 5;
  localparam int MT_FILT    = 4;
  localparam int MT_SRC     = 3;
  localparam int MT_DCSRC   = 2;
  localparam int MT_UTDSRC  = 1;
  localparam int MT_UTDEN   = 0;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LINE_NORMAL_ACTIVE = 3'h0,
    LINE_EXT_RING      = 3'h1,
    LINE_INT_RING      = 3'h2,
    LINE_RING_OPEN     = 3'h3,
    LINE_TIP_OPEN      = 3'h4,
    LINE_INT_TEST      = 3'h5,
    LINE_LOW_PWR_STBY  = 3'h6,
    LINE_POWER_DOWN    = 3'h7
  } line_chip_state_t;

  typedef struct packed {
    logic modemLowpassEn;
    logic highpassBypass;
    logic meterBandpassCoefSrc;
    logic meterNotchCoefSrc;
    logic toneDetectCoefSrc;
    logic signalThreshCoefSrc;
    logic feedCurveCoefSrc;
    logic ringRampCoefSrc;
  } filter_cfg_t;

  typedef struct packed {
    logic powerDown;
    logic standby;
    logic active;
    logic ramp;
    logic ringing;
  } codec_mode_t;

  typedef struct packed {
    logic             lineChipAccess;
    line_chip_state_t lineChipState;
  } line_mode_t;

  typedef struct packed {
    logic impedanceScale;
    logic tripTypeSelect;
    logic ringGenEn;
    logic tone2En;
    logic tone1En;
    logic rampGenEn;
    logic meterNotchChar;
    logic meterFiltEn;
    logic meterSrc;
    logic meterDcSrc;
    logic toneDetectSrc;
    logic toneDetectEn;
  } gen_meter_cfg_t;

endpackage

// file: channel_mode_filter_config_regs.sv
// per-channel filter, mode, generator and meter configuration registers
// Functional notes
// RULE_01 - command byte bit 7 is direction, low bits index; 04H write, 84H read
// RULE_02 - filter bit 7 zero enables modem lowpass; resets to one (off)
// RULE_03 - filter bit 6 zero keeps highpass active; one bypasses it; reset zero
// RULE_04 - filter bit 5 meter bandpass coefficients: zero RAM, one ROM (reset)
// RULE_05 - filter bit 4 meter notch coefficients: zero RAM, one ROM (reset)
// RULE_06 - filter bit 3 tone detector coefficients and threshold: RAM or ROM
// RULE_07 - filter bit 2 hook, ground-key, trip thresholds: zero RAM, one ROM
// RULE_08 - filter bit 1 feed curve coefficients: zero RAM, one ROM (reset)
// RULE_09 - filter bit 0 ring and ramp generator coefficients: RAM or ROM
// RULE_10 - mode upper nibble plus ring bit set codec mode; low nibble line mode
// RULE_11 - mode bit 7 sets codec power-down; set at reset
// RULE_12 - mode bit 6 enables codec standby; resets to zero
// RULE_13 - mode bit 5 enables active, bit 4 enables ramp; both reset zero
// RULE_14 - low mode nibble used only on serial port; GCI byte used otherwise
// RULE_15 - mode bit 3 one makes the line chip accessed; reset zero
// RULE_16 - three-bit line state encodes eight line modes; reset normal active
// RULE_17 - register 06H bit 4 enables codec ringing mode
// RULE_18 - register 06H bit 3 trip type: zero AC (reset), one DC
// RULE_19 - register 07H written at 07H, read at 87H; generator and meter bits
// RULE_20 - reads return last write, reserved bits zero, defaults on reset
module channel_mode_filter_config_regs
  import chan_cfg_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       cmdValid,
  input  wire logic [7:0] cmdByte,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  output logic            rdValid,
  input  wire logic       gciPortSel,
  input  wire logic       gciLineAccess,
  input  wire logic [2:0] gciLineState,
  output filter_cfg_t     filterCfg,
  output codec_mode_t     codecMode,
  output line_mode_t      lineMode,
  output gen_meter_cfg_t  genMeterCfg
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // RULE_01 write command for one index
  function automatic logic writeHit(
    input logic       valid,
    input logic [7:0] command,
    input logic [6:0] index
  );
    logic dirRead;
    logic idxMatch;
    dirRead  = command[CMD_DIR_BIT];
    idxMatch = (command[CMD_DIR_BIT-1:0] == index);
    writeHit = valid & ~dirRead & idxMatch;
  endfunction

  // RULE_20 reserved bits cleared on write
  function automatic logic [7:0] maskedValue(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    maskedValue = data & mask;
  endfunction

  // RULE_20 readback selection, unmapped reads zero
  function automatic logic [7:0] readSelect(
    input logic [6:0] index,
    input logic [7:0] filterVal,
    input logic [7:0] modeVal,
    input logic [7:0] ringVal,
    input logic [7:0] meterVal
  );
    case (index)
      IDX_FILTER: readSelect = filterVal;
      IDX_MODE:   readSelect = modeVal;
      IDX_RING:   readSelect = ringVal;
      IDX_METER:  readSelect = meterVal;
      default:    readSelect = RD_IDLE;
    endcase
  endfunction

  // filter register into its controls
  function automatic filter_cfg_t decodeFilter(
    input logic [7:0] value
  );
    filter_cfg_t cfg;
    // RULE_02 modem lowpass on when the bit is zero
    cfg.modemLowpassEn       = ~value[FLT_MODEM];
    // RULE_03 highpass bypass
    cfg.highpassBypass       = value[FLT_HPF];
    // RULE_04 bandpass source
    cfg.meterBandpassCoefSrc = value[FLT_BAND];
    // RULE_05 notch source
    cfg.meterNotchCoefSrc    = value[FLT_NOTCH];
    // RULE_06 tone detector source
    cfg.toneDetectCoefSrc    = value[FLT_TONE];
    // RULE_07 threshold source
    cfg.signalThreshCoefSrc  = value[FLT_SIG];
    // RULE_08 feed curve source
    cfg.feedCurveCoefSrc     = value[FLT_FEED];
    // RULE_09 ring and ramp source
    cfg.ringRampCoefSrc      = value[FLT_RING];
    decodeFilter             = cfg;
  endfunction

  // RULE_10 codec mode from upper nibble and ring bit
  function automatic codec_mode_t decodeCodec(
    input logic [7:0] modeVal,
    input logic [7:0] ringVal
  );
    codec_mode_t cfg;
    // RULE_11 power-down bit
    cfg.powerDown = modeVal[MD_PDOWN];
    // RULE_12 standby bit
    cfg.standby   = modeVal[MD_STBY];
    // RULE_13 active and ramp
    cfg.active    = modeVal[MD_ACTIVE];
    cfg.ramp      = modeVal[MD_RAMP];
    // RULE_17 ringing mode bit
    cfg.ringing   = ringVal[RG_RING];
    decodeCodec   = cfg;
  endfunction

  // generator, trip and meter controls
  function automatic gen_meter_cfg_t decodeGenMeter(
    input logic [7:0] ringVal,
    input logic [7:0] meterVal
  );
    gen_meter_cfg_t cfg;
    cfg.impedanceScale = ringVal[RG_IMP];
    // RULE_18 trip type select
    cfg.tripTypeSelect = ringVal[RG_TRIP];
    cfg.ringGenEn      = ringVal[RG_RINGEN];
    cfg.tone2En        = ringVal[RG_TG2];
    cfg.tone1En        = ringVal[RG_TG1];
    // RULE_19 meter register fields
    cfg.rampGenEn      = meterVal[MT_RAMPEN];
    cfg.meterNotchChar = meterVal[MT_NOTCH];
    cfg.meterFiltEn    = meterVal[MT_FILT];
    cfg.meterSrc       = meterVal[MT_SRC];
    cfg.meterDcSrc     = meterVal[MT_DCSRC];
    cfg.toneDetectSrc  = meterVal[MT_UTDSRC];
    cfg.toneDetectEn   = meterVal[MT_UTDEN];
    decodeGenMeter     = cfg;
  endfunction

  // RULE_16 line state from the low nibble
  function automatic line_mode_t hostLineMode(
    input logic [7:0] modeVal
  );
    line_mode_t cfg;
    // RULE_15 line chip access
    cfg.lineChipAccess = modeVal[MD_SCAN];
    cfg.lineChipState  = line_chip_state_t'(modeVal[MD_SM_HI:0]);
    hostLineMode       = cfg;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic       [7:0] regFilter;
  logic       [7:0] regMode;
  logic       [7:0] regRing;
  logic       [7:0] regMeter;
  logic       [7:0] next_regFilter;
  logic       [7:0] next_regMode;
  logic       [7:0] next_regRing;
  logic       [7:0] next_regMeter;
  logic             isRead;
  logic       [6:0] cmdIndex;
  logic             wrFilter;
  logic             wrMode;
  logic             wrRing;
  logic             wrMeter;
  line_mode_t       hostLine;
  line_mode_t       gciLine;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // RULE_01 command decode
  assign isRead   = cmdValid & cmdByte[CMD_DIR_BIT];
  assign cmdIndex = cmdByte[CMD_DIR_BIT-1:0];
  assign wrFilter = writeHit(cmdValid, cmdByte, IDX_FILTER);
  assign wrMode   = writeHit(cmdValid, cmdByte, IDX_MODE);
  assign wrRing   = writeHit(cmdValid, cmdByte, IDX_RING);
  // RULE_19 meter register write index
  assign wrMeter  = writeHit(cmdValid, cmdByte, IDX_METER);

  // ----------------------------------------------------------------
  // filter register
  // ----------------------------------------------------------------
  // RULE_20 filter write with mask
  always_comb begin
    next_regFilter = regFilter;
    if (wrFilter) begin
      next_regFilter = maskedValue(wrData, MASK_FILTER);
    end
  end

  // RULE_02 filter defaults on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regFilter <= RST_FILTER;
    end else begin
      regFilter <= next_regFilter;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  // RULE_20 mode write with mask
  always_comb begin
    next_regMode = regMode;
    if (wrMode) begin
      next_regMode = maskedValue(wrData, MASK_MODE);
    end
  end

  // RULE_11 power-down set on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regMode <= RST_MODE;
    end else begin
      regMode <= next_regMode;
    end
  end

  // ----------------------------------------------------------------
  // ring and generator register
  // ----------------------------------------------------------------
  // RULE_20 reserved top bits cleared
  always_comb begin
    next_regRing = regRing;
    if (wrRing) begin
      next_regRing = maskedValue(wrData, MASK_RING);
    end
  end

  // RULE_18 ac trip on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRing <= RST_RING;
    end else begin
      regRing <= next_regRing;
    end
  end

  // ----------------------------------------------------------------
  // ramp and meter register
  // ----------------------------------------------------------------
  // RULE_19 meter write, reserved bit cleared
  always_comb begin
    next_regMeter = regMeter;
    if (wrMeter) begin
      next_regMeter = maskedValue(wrData, MASK_METER);
    end
  end

  // RULE_20 meter defaults on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regMeter <= RST_METER;
    end else begin
      regMeter <= next_regMeter;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // RULE_02 controls move with the register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filterCfg <= decodeFilter(RST_FILTER);
    end else begin
      filterCfg <= decodeFilter(next_regFilter);
    end
  end

  // RULE_10 codec controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      codecMode <= decodeCodec(RST_MODE, RST_RING);
    end else begin
      codecMode <= decodeCodec(next_regMode, next_regRing);
    end
  end

  // RULE_19 generator and meter controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      genMeterCfg <= decodeGenMeter(RST_RING, RST_METER);
    end else begin
      genMeterCfg <= decodeGenMeter(next_regRing, next_regMeter);
    end
  end

  // ----------------------------------------------------------------
  // line mode
  // ----------------------------------------------------------------
  // RULE_16 host line mode
  assign hostLine = hostLineMode(regMode);

  // RULE_14 downstream byte under the gci port
  always_comb begin
    gciLine.lineChipAccess = gciLineAccess;
    gciLine.lineChipState  = line_chip_state_t'(gciLineState);
  end

  // RULE_14 line mode source select
  always_comb begin
    if (gciPortSel) begin
      lineMode = gciLine;
    end else begin
      lineMode = hostLine;
    end
  end

  // ----------------------------------------------------------------
  // read strobe
  // ----------------------------------------------------------------
  // RULE_01 answer one cycle after a read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= isRead;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // RULE_20 readback of last write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= RD_IDLE;
    end else if (isRead) begin
      rdData <= readSelect(cmdIndex, regFilter, regMode, regRing, regMeter);
    end
  end

endmodule // channel_mode_filter_config_regs

// file: host_port_model.sv
// host side driver of the command byte port
module host_port_model (
  input  wire logic       sys_clk,
  output logic            cmdValid,
  output logic      [7:0] cmdByte,
  output logic      [7:0] wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    wrData = 8'h00;
  end
  task automatic send(input logic rdN, input logic [6:0] a,
                      input logic [7:0] d);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdByte <= {rdN, a};
    wrData <= d;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    wrData <= ~d;
    #1;
  endtask
endmodule // host_port_model

// file: tb_channel_mode_filter_config_regs.sv
// self-checking bench for the channel config bank
module tb_channel_mode_filter_config_regs
  import chan_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           sys_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           gciPortSel = 1'b0;
  logic           gciLineAccess = 1'b0;
  logic     [2:0] gciLineState = 3'h0;
  logic           cmdValid;
  logic           rdValid;
  logic     [7:0] cmdByte;
  logic     [7:0] wrData;
  logic     [7:0] rdData;
  filter_cfg_t    filterCfg;
  codec_mode_t    codecMode;
  line_mode_t     lineMode;
  gen_meter_cfg_t genMeterCfg;
  int             nMismatch = 0;
  int             cmpCount = 0;
  logic     [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hFF};
  logic     [7:0] msk [4] = '{8'hFF, 8'hFF, 8'h3F, 8'hBF};
  initial forever #2.5 sys_clk = ~sys_clk;
  host_port_model u_host_port_model (.sys_clk, .cmdValid, .cmdByte, .wrData);
  channel_mode_filter_config_regs u_channel_mode_filter_config_regs (
    .sys_clk, .rst_n, .cmdValid, .cmdByte, .wrData, .rdData, .rdValid,
    .gciPortSel, .gciLineAccess, .gciLineState, .filterCfg, .codecMode,
    .lineMode, .genMeterCfg);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host_port_model.send(1'b0, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_host_port_model.send(1'b1, a, 8'h00);
    chk({7'h00, rdValid, rdData}, {8'h01, e});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    nMismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(7'h04, 8'hBF);
    rd(7'h05, 8'h80);
    rd(7'h06, 8'h00);
    rd(7'h07, 8'h00);
    chk(16'(filterCfg), 16'h003F);
    chk(16'(codecMode), 16'h0010);
    chk(16'(lineMode), 16'h0000);
    chk(16'(genMeterCfg), 16'h0000);
    $display("test reset values done");
    foreach (pat[p]) for (int i = 0; i < 4; i++) begin
      wr(7'h04 + 7'(i), pat[p]);
      rd(7'h04 + 7'(i), pat[p] & msk[i]);
    end
    chk(16'(filterCfg), 16'h007F);
    chk(16'(codecMode), 16'h001F);
    chk(16'(genMeterCfg), 16'h0FFF);
    wr(7'h04, 8'h00);
    chk(16'(filterCfg), 16'h0080);
    $display("test readback done");
    for (int s = 0; s < 8; s++) begin
      wr(7'h05, {5'h11, 3'(s)});
      chk(16'(lineMode), {12'h000, 1'b1, 3'(s)});
    end
    @(posedge sys_clk);
    gciPortSel <= 1'b1;
    gciLineState <= 3'h5;
    @(posedge sys_clk);
    #1;
    chk(16'(lineMode), 16'h0005);
    @(posedge sys_clk);
    gciPortSel <= 1'b0;
    $display("test line modes done");
    wr(7'h08, 8'hFF);
    rd(7'h08, 8'h00);
    rd(7'h00, 8'h00);
    rd(7'h04, 8'h00);
    $display("test unmapped done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(7'h05, 8'h80);
    rd(7'h04, 8'hBF);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // tb_channel_mode_filter_config_regs
